/* File: verilog/skip_sub_defines.svh */
// Register map, field positions, reset values and cycle counts for the skip and subtract executor
// Assumes a 32-bit APB slave with byte addresses, one aligned word per register
`ifndef SKIP_SUB_DEFINES_SVH
`define SKIP_SUB_DEFINES_SVH

// Register byte addresses
`define REG_CMD 8'h00
`define REG_WREG 8'h04
`define REG_STATUS 8'h08
`define REG_MADDR 8'h0c
`define REG_MDATA 8'h10

// Command word fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_BIT_LSB 4
`define CMD_BIT_MSB 6
`define CMD_ADDR_LSB 8
`define CMD_ADDR_MSB 15
`define CMD_LIT_LSB 16
`define CMD_LIT_MSB 23

// Command codes
`define OPC_INC_SKIP_ZERO 3'h0
`define OPC_INC_TO_WREG_SKIP_ZERO 3'h1
`define OPC_SKIP_BIT_SET 3'h2
`define OPC_MINUS_INTO_WREG 3'h3
`define OPC_MINUS_INTO_MEMORY 3'h4
`define OPC_MINUS_LITERAL 3'h5

// Status word bit positions
`define STAT_CARRY 0
`define STAT_HALF_CARRY 1
`define STAT_ZERO 2
`define STAT_SIGNED_RANGE 3
`define STAT_BUSY 4
`define STAT_SKIP 5

// Reset values
`define WREG_RESET 8'h00
`define FLAGS_RESET 4'h0

// Machine cycles of a skip-type instruction
`define SKIP_MACHINE_CYCLES 2'h2

`endif

/* File: verilog/skip_sub_pkg.sv */
// Types shared by the skip and subtract executor
// Assumes nothing beyond a SystemVerilog compiler
package skip_sub_pkg;

   // Decoded instruction kinds
   typedef enum logic [2:0] {
      inc_skip_zero,
      inc_to_wreg_skip_zero,
      skip_bit_set,
      minus_into_wreg,
      minus_into_memory,
      minus_literal
   } op_t;

   // Sequencer states
   typedef enum logic [1:0] {
      st_idle,
      st_exec,
      st_second
   } state_t;

endpackage

/* File: verilog/skip_sub_alu.sv */
// Combinational arithmetic for increment and subtract
// Assumes operands are stable for the cycle in which results are used
`timescale 1ns/10ps
module skip_sub_alu #(
   parameter int WIDTH = 8
) (
   // Operands
   input wire logic [WIDTH-1:0] minuend,
   input wire logic [WIDTH-1:0] subtrahend,
   input wire logic [WIDTH-1:0] inc_operand,
   // Results
   output logic [WIDTH-1:0] inc_result,
   output logic [WIDTH-1:0] difference,
   output logic carry_flag,
   output logic half_carry_flag,
   output logic zero_flag,
   output logic signed_range_flag
);

   logic [WIDTH:0] wide_diff;
   logic [4:0] low_diff;

   // Increment wraps at the top of the byte
   assign inc_result = inc_operand + {{(WIDTH-1){1'b0}}, 1'b1};

   // Subtract with borrow out in the extra bit
   assign wide_diff = {1'b0, minuend} - {1'b0, subtrahend};
   assign low_diff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
   assign difference = wide_diff[WIDTH-1:0];

   // Flags, carry is the inverted borrow
   assign carry_flag = ~wide_diff[WIDTH];
   assign half_carry_flag = ~low_diff[4];
   assign zero_flag = (wide_diff[WIDTH-1:0] == '0);
   assign signed_range_flag = (minuend[WIDTH-1] ^ subtrahend[WIDTH-1]) &
                              (minuend[WIDTH-1] ^ wide_diff[WIDTH-1]);

endmodule

/* File: verilog/skip_and_subtract_exec.sv */
// Executor for increment-skip, bit-test skip and subtract instructions with an APB register port
// Assumes one clock pclk, presetn asynchronous active low, APB master per the published protocol
`timescale 1ns/10ps
`include "skip_sub_defines.svh"
module skip_and_subtract_exec #(
   parameter int DEPTH = 160,
   parameter int AW = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Sequencing status
   output logic busy,
   output logic skip_next,
   output logic dummy_cycle
);

   skip_sub_pkg::state_t state_reg;
   skip_sub_pkg::op_t op_reg;
   skip_sub_pkg::op_t op_next;
   logic op_valid;
   logic [AW-1:0] addr_reg;
   logic [2:0] bit_reg;
   logic [7:0] lit_reg;
   logic [7:0] working_register_reg;
   logic [3:0] flags_reg;
   logic [AW-1:0] maddr_reg;
   logic [31:0] prdata_reg;
   logic skip_reg;
   logic dummy_reg;
   logic [7:0] mem_reg [DEPTH];
   logic [7:0] operand;
   logic [7:0] host_byte;
   logic [7:0] sub_right;
   logic [7:0] inc_result;
   logic [7:0] difference;
   logic alu_c;
   logic alu_ac;
   logic alu_z;
   logic alu_ov;
   logic access;
   logic wr;
   logic mapped;
   logic cmd_wr;
   logic refused;
   logic in_exec;
   logic skip_cond;
   logic is_skip_op;

   // Memory reads, out-of-range addresses read zero
   assign operand = (int'(addr_reg) < DEPTH) ? mem_reg[addr_reg] : 8'h00;
   assign host_byte = (int'(maddr_reg) < DEPTH) ? mem_reg[maddr_reg] : 8'h00;

   // Right operand is the literal only for the immediate form
   assign sub_right = (op_reg == skip_sub_pkg::minus_literal) ? lit_reg : operand;

   skip_sub_alu #(
      .WIDTH(8)
   ) alu_inst (
      .minuend(working_register_reg),
      .subtrahend(sub_right),
      .inc_operand(operand),
      .inc_result(inc_result),
      .difference(difference),
      .carry_flag(alu_c),
      .half_carry_flag(alu_ac),
      .zero_flag(alu_z),
      .signed_range_flag(alu_ov)
   );

   // Command code decode
   always_comb begin
      op_valid = 1'b1;
      case (pwdata[`CMD_OP_MSB:`CMD_OP_LSB])
         `OPC_INC_SKIP_ZERO: op_next = skip_sub_pkg::inc_skip_zero;
         `OPC_INC_TO_WREG_SKIP_ZERO: op_next = skip_sub_pkg::inc_to_wreg_skip_zero;
         `OPC_SKIP_BIT_SET: op_next = skip_sub_pkg::skip_bit_set;
         `OPC_MINUS_INTO_WREG: op_next = skip_sub_pkg::minus_into_wreg;
         `OPC_MINUS_INTO_MEMORY: op_next = skip_sub_pkg::minus_into_memory;
         `OPC_MINUS_LITERAL: op_next = skip_sub_pkg::minus_literal;
         default: begin
            op_next = skip_sub_pkg::inc_skip_zero;
            op_valid = 1'b0;
         end
      endcase
   end

   // APB decode and error answer
   assign access = psel & penable;
   assign mapped = (paddr == `REG_CMD) | (paddr == `REG_WREG) | (paddr == `REG_STATUS) |
                   (paddr == `REG_MADDR) | (paddr == `REG_MDATA);
   assign refused = ~mapped | (pwrite & (busy | ((paddr == `REG_CMD) & ~op_valid)));
   assign wr = access & pwrite & ~refused;
   assign cmd_wr = wr & (paddr == `REG_CMD);
   assign pready = 1'b1;
   assign pslverr = access & refused;
   assign prdata = prdata_reg;

   // Skip decisions taken in the execute cycle
   assign in_exec = (state_reg == skip_sub_pkg::st_exec);
   assign is_skip_op = (op_reg == skip_sub_pkg::inc_skip_zero) |
                       (op_reg == skip_sub_pkg::inc_to_wreg_skip_zero) |
                       (op_reg == skip_sub_pkg::skip_bit_set);
   always_comb begin
      case (op_reg)
         skip_sub_pkg::inc_skip_zero: skip_cond = (inc_result == 8'h00);
         skip_sub_pkg::inc_to_wreg_skip_zero: skip_cond = (inc_result == 8'h00);
         skip_sub_pkg::skip_bit_set: skip_cond = operand[bit_reg];
         default: skip_cond = 1'b0;
      endcase
   end

   // Sequencer, skip forms hold a second machine cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= skip_sub_pkg::st_idle;
      end else begin
         case (state_reg)
            skip_sub_pkg::st_idle: begin
               if (cmd_wr) begin
                  state_reg <= skip_sub_pkg::st_exec;
               end
            end
            skip_sub_pkg::st_exec: begin
               if (is_skip_op) begin
                  state_reg <= skip_sub_pkg::st_second;
               end else begin
                  state_reg <= skip_sub_pkg::st_idle;
               end
            end
            skip_sub_pkg::st_second: state_reg <= skip_sub_pkg::st_idle;
            default: state_reg <= skip_sub_pkg::st_idle;
         endcase
      end
   end

   // Instruction latch on command write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_reg <= skip_sub_pkg::inc_skip_zero;
         addr_reg <= '0;
         bit_reg <= 3'h0;
         lit_reg <= 8'h00;
      end else if (cmd_wr) begin
         op_reg <= op_next;
         addr_reg <= pwdata[`CMD_ADDR_LSB +: AW];
         bit_reg <= pwdata[`CMD_BIT_MSB:`CMD_BIT_LSB];
         lit_reg <= pwdata[`CMD_LIT_MSB:`CMD_LIT_LSB];
      end
   end

   // Working register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         working_register_reg <= `WREG_RESET;
      end else if (in_exec) begin
         case (op_reg)
            skip_sub_pkg::inc_to_wreg_skip_zero: working_register_reg <= inc_result;
            skip_sub_pkg::minus_into_wreg: working_register_reg <= difference;
            skip_sub_pkg::minus_literal: working_register_reg <= difference;
            default: working_register_reg <= working_register_reg;
         endcase
      end else if (wr & (paddr == `REG_WREG)) begin
         working_register_reg <= pwdata[7:0];
      end
   end

   // Status flags, only the subtracts and host writes to the status register touch them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_reg <= `FLAGS_RESET;
      end else if (in_exec & ~is_skip_op) begin
         flags_reg[`STAT_CARRY] <= alu_c;
         flags_reg[`STAT_HALF_CARRY] <= alu_ac;
         flags_reg[`STAT_ZERO] <= alu_z;
         flags_reg[`STAT_SIGNED_RANGE] <= alu_ov;
      end else if (wr & (paddr == `REG_STATUS)) begin
         flags_reg <= pwdata[3:0];
      end
   end

   // Data memory, instruction results or host writes
   always_ff @(posedge pclk) begin
      if (in_exec & (int'(addr_reg) < DEPTH)) begin
         if (op_reg == skip_sub_pkg::inc_skip_zero) begin
            mem_reg[addr_reg] <= inc_result;
         end else if (op_reg == skip_sub_pkg::minus_into_memory) begin
            mem_reg[addr_reg] <= difference;
         end
      end else if (wr & (paddr == `REG_MDATA) & (int'(maddr_reg) < DEPTH)) begin
         mem_reg[maddr_reg] <= pwdata[7:0];
      end
   end

   // Host memory pointer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         maddr_reg <= '0;
      end else if (wr & (paddr == `REG_MADDR)) begin
         maddr_reg <= pwdata[AW-1:0];
      end
   end

   // Skip outcome and dummy cycle marker
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_reg <= 1'b0;
         dummy_reg <= 1'b0;
      end else begin
         dummy_reg <= in_exec & is_skip_op & skip_cond;
         if (cmd_wr) begin
            skip_reg <= 1'b0;
         end else if (in_exec) begin
            skip_reg <= skip_cond;
         end
      end
   end

   assign busy = (state_reg != skip_sub_pkg::st_idle);
   assign skip_next = skip_reg;
   assign dummy_cycle = dummy_reg;

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `REG_WREG: prdata_reg <= {24'h000000, working_register_reg};
            `REG_STATUS: prdata_reg <= {26'h0000000, skip_reg, busy, flags_reg};
            `REG_MADDR: prdata_reg <= 32'(maddr_reg);
            `REG_MDATA: prdata_reg <= {24'h000000, host_byte};
            default: prdata_reg <= 32'h00000000;
         endcase
      end
   end

endmodule

/* File: sim/skip_and_subtract_exec_checker.sv */
// Port-level checks for the skip and subtract executor
// Assumes one clock pclk and presetn asynchronous active low
`timescale 1ns/10ps
module skip_and_subtract_exec_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Sequencing status
   input wire logic busy,
   input wire logic skip_next,
   input wire logic dummy_cycle
);
   logic acc, cmd_go, skip_go, sub_go;
   // Accepted commands split by kind
   assign acc = psel && penable && pwrite;
   assign cmd_go = acc && paddr == 8'h00 && !busy && pwdata[2:0] < 3'h6;
   assign skip_go = cmd_go && pwdata[2:0] < 3'h3;
   assign sub_go = cmd_go && pwdata[2:0] > 3'h2;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence two_busy;
      busy [*2] ##1 !busy;
   endsequence
   sequence one_busy;
      busy ##1 !busy;
   endsequence
   a_pready_high: assert property (pready) else $error("pready low");
   a_skip_two_cycles: assert property (skip_go |=> two_busy) else $error("skip length");
   a_sub_one_cycle: assert property (sub_go |=> one_busy) else $error("sub length");
   a_sub_no_skip: assert property (sub_go |=> (!skip_next && !dummy_cycle) [*2])
      else $error("sub skipped");
   a_dummy_in_skip: assert property (dummy_cycle |-> busy && skip_next && $past(busy))
      else $error("stray dummy");
   a_dummy_one_pulse: assert property (dummy_cycle |=> !dummy_cycle) else $error("dummy long");
   a_skip_stands: assert property (!busy && !(acc && paddr == 8'h00) |=> $stable(skip_next))
      else $error("skip moved");
   a_busy_write_refused: assert property (acc && busy |-> pslverr) else $error("busy write");
   a_bad_op_refused: assert property (acc && paddr == 8'h00 && pwdata[2:0] > 3'h5 |-> pslverr)
      else $error("bad op");
   a_unmapped_read: assert property (psel && penable && !pwrite && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
      else $error("unmapped read");
endmodule
bind skip_and_subtract_exec skip_and_subtract_exec_checker skip_and_subtract_exec_checker_i (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy(busy), .skip_next(skip_next),
   .dummy_cycle(dummy_cycle));

/* File: sim/tb_skip_and_subtract_exec.sv */
// Self-checking bench for the skip and subtract executor
// Assumes design and checker files are compiled first
`timescale 1ns/10ps
`include "skip_sub_defines.svh"
module tb_skip_and_subtract_exec;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, skip_next, dummy_cycle, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int miscompares, compares, nb, nd;

   // Design under test
   skip_and_subtract_exec skip_and_subtract_exec_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .busy(busy), .skip_next(skip_next), .dummy_cycle(dummy_cycle));

   // Clock at 8 ns
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; keep leaves psel up for a back-to-back setup
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic keep = 1'b0);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      penable <= 1'b0;
      if (!keep) begin
         psel <= 1'b0;
         @(posedge pclk);
      end
   endtask

   // Issue a command, count busy and dummy cycles
   task automatic cmd(input logic [2:0] op, input logic [2:0] bi, input logic [7:0] a, input logic [7:0] lit);
      apb(1'b1, `REG_CMD, {8'h00, lit, a, 1'b0, bi, 1'b0, op});
      nb = 0;
      nd = 0;
      repeat (3) begin
         nb += (busy === 1'b1);
         nd += (dummy_cycle === 1'b1);
         @(posedge pclk);
      end
   endtask

   task automatic skipchk(input logic s);
      chk(skip_next, s);
      chk(nd, s);
      chk(nb, 2);
   endtask

   task automatic setmem(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, `REG_MADDR, {24'h0, a});
      apb(1'b1, `REG_MDATA, {24'h0, d});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // Increment in memory, wrap skips, flags kept
   task automatic t_inc;
      setmem(8'h05, 8'hff);
      apb(1'b1, `REG_STATUS, 32'h0000000a);
      cmd(`OPC_INC_SKIP_ZERO, 3'h0, 8'h05, 8'h00);
      skipchk(1'b1);
      rdchk(`REG_MDATA, 32'h0);
      rdchk(`REG_STATUS, 32'h0000002a);
      cmd(`OPC_INC_SKIP_ZERO, 3'h0, 8'h05, 8'h00);
      skipchk(1'b0);
      rdchk(`REG_MDATA, 32'h1);
      $display("test inc done");
   endtask

   // Increment into working register, memory untouched
   task automatic t_wreg;
      setmem(8'h09, 8'hff);
      cmd(`OPC_INC_TO_WREG_SKIP_ZERO, 3'h0, 8'h09, 8'h00);
      skipchk(1'b1);
      rdchk(`REG_WREG, 32'h0);
      rdchk(`REG_MDATA, 32'hff);
      setmem(8'h09, 8'h41);
      cmd(`OPC_INC_TO_WREG_SKIP_ZERO, 3'h0, 8'h09, 8'h00);
      skipchk(1'b0);
      rdchk(`REG_WREG, 32'h42);
      $display("test wreg done");
   endtask

   // Every bit index, set and clear
   task automatic t_bit;
      for (int i = 0; i < 8; i++) begin
         setmem(8'h03, 8'h01 << i);
         cmd(`OPC_SKIP_BIT_SET, i[2:0], 8'h03, 8'h00);
         skipchk(1'b1);
         cmd(`OPC_SKIP_BIT_SET, 3'(i + 1), 8'h03, 8'h00);
         skipchk(1'b0);
      end
      $display("test bit done");
   endtask

   // Three subtract forms over flag corner cases
   task automatic t_sub;
      logic [7:0] w [6] = '{8'h50, 8'h20, 8'h80, 8'h7f, 8'h33, 8'h10};
      logic [7:0] m [6] = '{8'h20, 8'h50, 8'h01, 8'hff, 8'h33, 8'h01};
      logic [7:0] d;
      int j;
      for (int k = 0; k < 18; k++) begin
         j = k % 6;
         d = w[j] - m[j];
         apb(1'b1, `REG_WREG, {24'h0, w[j]});
         setmem(8'h04, m[j]);
         cmd(3'(3 + k / 6), 3'h0, 8'h04, m[j]);
         chk(nb, 1);
         rdchk(`REG_WREG, k / 6 == 1 ? w[j] : d);
         rdchk(`REG_MDATA, k / 6 == 1 ? d : m[j]);
         rdchk(`REG_STATUS, {(w[j][7] != m[j][7]) && (d[7] != w[j][7]), d == 8'h00,
            w[j][3:0] >= m[j][3:0], w[j] >= m[j]});
      end
      $display("test sub done");
   endtask

   // Refused requests leave state alone
   task automatic t_refuse;
      apb(1'b0, 8'h14, 32'h0);
      chk(er, 1);
      chk(rd, 32'h0);
      apb(1'b1, `REG_CMD, 32'h6);
      chk(er, 1);
      apb(1'b1, `REG_WREG, 32'h11);
      apb(1'b1, `REG_CMD, 32'h0302, 1'b1);
      apb(1'b1, `REG_WREG, 32'h55);
      chk(er, 1);
      rdchk(`REG_WREG, 32'h11);
      $display("test refuse done");
   endtask

   task automatic finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      #100000;
      miscompares++;
      finish_test;
   end

   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`REG_STATUS, 32'h0);
      t_inc;
      t_wreg;
      t_bit;
      t_sub;
      t_refuse;
      finish_test;
   end
endmodule
